// File: rtl/hpfd_pkg.sv
// constants and types of the host port with firmware download
package hpfd_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_HOST_COMMAND = 8'h00;
    localparam logic [7:0] OFF_DEVICE_REQUEST = 8'h04;
    localparam logic [7:0] OFF_HOST_COMMAND_REF_ID = 8'h08;
    localparam logic [7:0] OFF_DEVICE_COMMAND_ID = 8'h0c;
    localparam logic [7:0] OFF_EXECUTED_COMMAND_ID = 8'h10;
    localparam logic [7:0] OFF_COMMAND_RESPONSE = 8'h14;
    localparam logic [7:0] OFF_HOST_TARGET_DEVICE_ADDR = 8'h18;
    localparam logic [7:0] OFF_DEVICE_TARGET_DEVICE_ADDR = 8'h1c;
    localparam logic [7:0] OFF_HOST_ENDPOINT_ADDR = 8'h20;
    localparam logic [7:0] OFF_DEVICE_ENDPOINT_ADDR = 8'h24;
    localparam logic [7:0] OFF_PACKET_TYPE_TOGGLE = 8'h28;
    localparam logic [7:0] OFF_PEER_CLASS_CODE = 8'h2c;
    localparam logic [7:0] OFF_PEER_SUBCLASS_CODE = 8'h30;
    localparam logic [7:0] OFF_PEER_PROTOCOL_CODE = 8'h34;
    localparam logic [7:0] OFF_PEER_VENDOR_IDENT = 8'h38;
    localparam logic [7:0] OFF_PEER_PRODUCT_IDENT = 8'h3c;
    localparam logic [7:0] OFF_HUB_DEVICE_ADDR = 8'h40;
    localparam logic [7:0] OFF_HUB_PORT_NUMBER = 8'h44;
    localparam logic [7:0] OFF_PACKET_SIZE = 8'h48;
    localparam logic [7:0] OFF_RETRY_LIMIT = 8'h4c;
    localparam logic [7:0] OFF_TRANSFER_MODE_SELECT = 8'h50;
    localparam logic [7:0] OFF_SEND_BUFFER_ADDR = 8'h54;
    localparam logic [7:0] OFF_SEND_BYTE_COUNT = 8'h58;
    localparam logic [7:0] OFF_GET_BUFFER_ADDR = 8'h5c;
    localparam logic [7:0] OFF_GET_BYTE_COUNT = 8'h60;
    localparam logic [7:0] OFF_TRANSFER_BUFFER_ADDR = 8'h64;
    localparam logic [7:0] OFF_TRANSFER_BYTE_COUNT = 8'h68;
    localparam logic [7:0] OFF_BYTES_MOVED_COUNT = 8'h6c;
    localparam logic [7:0] OFF_COMMAND_PARAMETER = 8'h70;
    localparam logic [7:0] OFF_CONFIGURATION_NUMBER = 8'h74;
    localparam logic [7:0] OFF_INTERFACE_NUMBER = 8'h78;
    localparam logic [7:0] OFF_ALTERNATE_SETTING_NUMBER = 8'h7c;
    localparam logic [7:0] OFF_REQUEST_PARAMETER_0 = 8'h80;
    localparam logic [7:0] OFF_REQUEST_PARAMETER_1 = 8'h84;
    localparam logic [7:0] OFF_PARAMETER_HANDSHAKE = 8'h88;
    localparam logic [7:0] OFF_FIFO_DATA_WINDOW = 8'hff;

    // register file shape and write permissions, bit n is offset 4*n
    localparam int NUM_REGS = 35;
    localparam logic [NUM_REGS-1:0] HOST_WR_MASK = 35'h4_11fc_0545;
    localparam logic [NUM_REGS-1:0] CTRL_WR_MASK = 35'h7_ee03_faba;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // field positions
    localparam int FW_ADDR_LSB = 0;
    localparam int FW_INSTR_LSB = 16;
    localparam int DMA_EN_BIT = 0;
    localparam logic TARGET_USB = 1'b0;

    // download handshake states, gray along the word cycle
    typedef enum logic [1:0] {
        HPFD_DL_IDLE = 2'b00,
        HPFD_DL_STORE = 2'b01,
        HPFD_DL_ACK = 2'b11,
        HPFD_DL_RELEASE = 2'b10
    } hpfd_dl_type;

    // pin levels sampled from the external processor
    typedef struct packed {
        logic rst_n;
        logic clk_sel;
        logic program_mode;
        logic sel;
        logic done;
        logic dma_ack_n;
        logic re_n;
        logic we_n;
        logic cs_n;
        logic [7:0] addr;
        logic [31:0] data;
    } hpfd_pin_type;

    localparam hpfd_pin_type PIN_IDLE = '{rst_n: 1'b1, clk_sel: 1'b0,
        program_mode: 1'b0, sel: 1'b0, done: 1'b0, dma_ack_n: 1'b1, re_n: 1'b1,
        we_n: 1'b1, cs_n: 1'b1, addr: 8'h00, data: 32'h0000_0000};

endpackage

// File: rtl/hpfd_host_port.sv
// system processor port with registers, fifo window, dma and fw download
`timescale 1ns/10ps

module hpfd_host_port
    import hpfd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_rst_n,
    input wire logic i_clk_sel,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_data,
    output logic [31:0] o_data,
    output logic o_data_oe,
    input wire logic i_cs_n,
    input wire logic i_we_n,
    input wire logic i_re_n,
    output logic o_dma_req,
    input wire logic i_dma_ack_n,
    input wire logic i_target_sel,
    input wire logic i_program_mode,
    input wire logic i_cycle_done,
    output logic o_word_stored,
    output logic o_pm_wr_usb,
    output logic o_pm_wr_sic,
    output logic [15:0] o_pm_addr,
    output logic [15:0] o_pm_instr,
    output logic o_ctrl_reset,
    output logic o_ext_clk_sel,
    input wire logic i_ctl_we,
    input wire logic [7:0] i_ctl_addr,
    input wire logic [31:0] i_ctl_wdata,
    output logic o_fifo_wvalid,
    output logic [31:0] o_fifo_wdata,
    input wire logic i_fifo_wready,
    input wire logic i_fifo_rvalid,
    input wire logic [31:0] i_fifo_rdata,
    output logic o_fifo_rpop
);

    typedef struct packed {
        hpfd_pin_type s1;
        hpfd_pin_type s2;
        logic [NUM_REGS-1:0][31:0] regs;
        logic busy;
        hpfd_dl_type dl;
        logic [31:0] rd_data;
        logic data_oe;
        logic word_stored;
        logic pm_wr_usb;
        logic pm_wr_sic;
        logic [15:0] pm_addr;
        logic [15:0] pm_instr;
        logic program_mode_q;
        logic ctrl_reset;
        logic ext_clk_sel;
        logic dma_req;
        logic head_v;
        logic [31:0] head;
        logic tail_v;
        logic [31:0] tail;
        logic rpop;
    } hpfd_state_type;

    hpfd_state_type st;
    hpfd_state_type next_st;

    // fill the next state from the current one and the inputs
    always_comb begin
        logic rst;
        logic cs;
        logic wr;
        logic rd;
        logic dma_wr;
        logic dma_rd;
        logic aligned;
        logic mapped;
        logic window;
        logic [5:0] idx;
        logic pop;
        logic push;
        logic full;
        logic [31:0] wdata;
        next_st = st;
        rst = 1'b0;
        cs = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        dma_wr = 1'b0;
        dma_rd = 1'b0;
        aligned = 1'b0;
        mapped = 1'b0;
        window = 1'b0;
        idx = 6'h00;
        pop = 1'b0;
        push = 1'b0;
        full = 1'b0;
        wdata = st.s2.data;

        // two-flop sampling of every pin
        next_st.s1 = '{rst_n: i_rst_n, clk_sel: i_clk_sel,
            program_mode: i_program_mode, sel: i_target_sel, done: i_cycle_done,
            dma_ack_n: i_dma_ack_n, re_n: i_re_n, we_n: i_we_n,
            cs_n: i_cs_n, addr: i_addr, data: i_data};
        next_st.s2 = st.s1;

        // decode of the synchronised strobe levels
        rst = !st.s2.rst_n;
        cs = !st.s2.cs_n;
        wr = cs && !st.s2.we_n;
        rd = cs && !st.s2.re_n;
        dma_wr = !st.s2.dma_ack_n && !st.s2.we_n;
        dma_rd = !st.s2.dma_ack_n && !st.s2.re_n;
        aligned = (st.s2.addr[1:0] == 2'b00);
        idx = st.s2.addr[7:2];
        mapped = aligned && (st.s2.addr <= OFF_PARAMETER_HANDSHAKE);
        window = (st.s2.addr == OFF_FIFO_DATA_WINDOW) || dma_wr || dma_rd;
        full = st.head_v && st.tail_v;

        // clock source strap level follows the pin
        next_st.ext_clk_sel = st.s2.clk_sel;

        // bus access is taken once per strobe assertion
        next_st.rpop = 1'b0;
        next_st.data_oe = 1'b1;
        next_st.rd_data = 32'h0000_0000;
        if (!(cs || dma_wr || dma_rd)) begin
            next_st.busy = 1'b0;
        end
        if (rd || dma_rd) begin
            next_st.data_oe = 1'b0;
            if (window) begin
                next_st.rd_data = i_fifo_rdata;
            end else if (mapped) begin
                next_st.rd_data = st.regs[idx];
            end else begin
                next_st.rd_data = 32'h0000_0000;
            end
            if (window && !st.busy && i_fifo_rvalid && !st.s2.program_mode) begin
                next_st.rpop = 1'b1;
                next_st.busy = 1'b1;
            end
        end

        // two-entry buffer towards the fifo, drained by the fifo side
        pop = st.head_v && i_fifo_wready;
        if (pop) begin
            next_st.head_v = st.tail_v;
            next_st.head = st.tail;
            next_st.tail_v = 1'b0;
        end

        // host register and window writes outside program mode
        if ((wr || dma_wr) && !st.busy && !st.s2.program_mode) begin
            if (window) begin
                if (!full) begin
                    push = 1'b1;
                    next_st.busy = 1'b1;
                end
            end else begin
                next_st.busy = 1'b1;
                if (mapped && HOST_WR_MASK[idx]) begin
                    next_st.regs[idx] = wdata;
                end
            end
        end
        if (push) begin
            if (!next_st.head_v) begin
                next_st.head_v = 1'b1;
                next_st.head = wdata;
            end else begin
                next_st.tail_v = 1'b1;
                next_st.tail = wdata;
            end
        end

        // internal controllers update their own registers
        if (i_ctl_we && (i_ctl_addr[1:0] == 2'b00)
                && (i_ctl_addr <= OFF_PARAMETER_HANDSHAKE)) begin
            if (CTRL_WR_MASK[i_ctl_addr[7:2]]) begin
                next_st.regs[i_ctl_addr[7:2]] = i_ctl_wdata;
            end
        end

        // dma request while enabled, the buffer has room and program mode is off
        next_st.dma_req = st.regs[OFF_TRANSFER_MODE_SELECT[7:2]][DMA_EN_BIT]
            && !next_st.tail_v && !st.s2.program_mode;

        // firmware word handshake
        next_st.pm_wr_usb = 1'b0;
        next_st.pm_wr_sic = 1'b0;
        case (st.dl)
            HPFD_DL_IDLE: begin
                if (st.s2.program_mode && wr && !st.busy) begin
                    next_st.busy = 1'b1;
                    next_st.pm_addr = wdata[FW_ADDR_LSB +: 16];
                    next_st.pm_instr = wdata[FW_INSTR_LSB +: 16];
                    if (st.s2.sel == TARGET_USB) begin
                        next_st.pm_wr_usb = 1'b1;
                    end else begin
                        next_st.pm_wr_sic = 1'b1;
                    end
                    next_st.dl = HPFD_DL_STORE;
                end
            end
            HPFD_DL_STORE: begin
                next_st.word_stored = 1'b1;
                next_st.dl = HPFD_DL_ACK;
            end
            HPFD_DL_ACK: begin
                if (st.s2.done) begin
                    next_st.word_stored = 1'b0;
                    next_st.dl = HPFD_DL_RELEASE;
                end
            end
            HPFD_DL_RELEASE: begin
                if (!st.s2.done) begin
                    next_st.dl = HPFD_DL_IDLE;
                end
            end
            default: begin
                next_st.dl = HPFD_DL_IDLE;
            end
        endcase

        // leaving program mode drops the handshake and restarts controllers
        next_st.program_mode_q = st.s2.program_mode;
        if (!st.s2.program_mode) begin
            next_st.dl = HPFD_DL_IDLE;
            next_st.word_stored = 1'b0;
        end
        next_st.ctrl_reset = st.s2.program_mode || (st.program_mode_q && !st.s2.program_mode);

        // pin reset restores every register default
        if (rst) begin
            next_st.regs = {NUM_REGS{REG_RESET}};
            next_st.busy = 1'b0;
            next_st.dl = HPFD_DL_IDLE;
            next_st.word_stored = 1'b0;
            next_st.pm_wr_usb = 1'b0;
            next_st.pm_wr_sic = 1'b0;
            next_st.ctrl_reset = 1'b1;
            next_st.dma_req = 1'b0;
            next_st.head_v = 1'b0;
            next_st.tail_v = 1'b0;
            next_st.rpop = 1'b0;
            next_st.data_oe = 1'b1;
        end
    end

    // register the state, clock reset returns constants only
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st.s1 <= PIN_IDLE;
            st.s2 <= PIN_IDLE;
            st.regs <= {NUM_REGS{REG_RESET}};
            st.busy <= 1'b0;
            st.dl <= HPFD_DL_IDLE;
            st.rd_data <= 32'h0000_0000;
            st.data_oe <= 1'b1;
            st.word_stored <= 1'b0;
            st.pm_wr_usb <= 1'b0;
            st.pm_wr_sic <= 1'b0;
            st.pm_addr <= 16'h0000;
            st.pm_instr <= 16'h0000;
            st.program_mode_q <= 1'b0;
            st.ctrl_reset <= 1'b1;
            st.ext_clk_sel <= 1'b0;
            st.dma_req <= 1'b0;
            st.head_v <= 1'b0;
            st.head <= 32'h0000_0000;
            st.tail_v <= 1'b0;
            st.tail <= 32'h0000_0000;
            st.rpop <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops
    assign o_data = st.rd_data;
    assign o_data_oe = st.data_oe;
    assign o_dma_req = st.dma_req;
    assign o_word_stored = st.word_stored;
    assign o_pm_wr_usb = st.pm_wr_usb;
    assign o_pm_wr_sic = st.pm_wr_sic;
    assign o_pm_addr = st.pm_addr;
    assign o_pm_instr = st.pm_instr;
    assign o_ctrl_reset = st.ctrl_reset;
    assign o_ext_clk_sel = st.ext_clk_sel;
    assign o_fifo_wvalid = st.head_v;
    assign o_fifo_wdata = st.head;
    assign o_fifo_rpop = st.rpop;

endmodule // hpfd_host_port

// File: tb/hpfd_host_port_asserts.sv
// assertion checker for the host port, bound to its ports
`timescale 1ns/10ps
module hpfd_host_port_asserts
    import hpfd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_rst_n,
    input wire logic [31:0] i_data,
    input wire logic i_re_n,
    input wire logic i_program_mode,
    input wire logic i_target_sel,
    input wire logic i_cycle_done,
    input wire logic i_fifo_wready,
    input wire logic [31:0] o_data,
    input wire logic o_data_oe,
    input wire logic o_word_stored,
    input wire logic o_pm_wr_usb,
    input wire logic o_pm_wr_sic,
    input wire logic [15:0] o_pm_addr,
    input wire logic [15:0] o_pm_instr,
    input wire logic o_ctrl_reset,
    input wire logic o_fifo_wvalid,
    input wire logic [31:0] o_fifo_wdata,
    input wire logic o_fifo_rpop
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    // download handshake and program memory writes
    AST_ACK: assert property ((o_pm_wr_usb || o_pm_wr_sic) |=> o_word_stored)
        else $error("no word stored after program write");
    AST_ACK_DROP: assert property (i_cycle_done [*4] |-> !o_word_stored)
        else $error("word stored still high after done");
    AST_SEL: assert property ((o_pm_wr_usb || o_pm_wr_sic) |->
        o_pm_wr_sic == ($past(i_target_sel, 2) != TARGET_USB))
        else $error("program write went to wrong controller");
    AST_WORD: assert property ((o_pm_wr_usb || o_pm_wr_sic) |->
        {o_pm_instr, o_pm_addr} == $past(i_data, 2))
        else $error("program address or instruction wrong");
    AST_PROGRAM_MODE: assert property ((o_pm_wr_usb || o_pm_wr_sic) |->
        $past(i_program_mode, 3))
        else $error("program write outside program mode");
    // read path
    AST_OE: assert property (!o_data_oe |-> !$past(i_re_n, 3))
        else $error("data driven without read strobe");
    AST_IDLE0: assert property (o_data_oe |-> o_data == 32'h0)
        else $error("read data not zero while idle");
    // controller restart around program mode
    AST_RUN: assert property ((!i_program_mode && i_rst_n) [*6] |-> !o_ctrl_reset)
        else $error("controllers held in reset while running");
    AST_HOLD: assert property ($past(i_program_mode, 2) &&
        $past(i_program_mode, 3) |-> o_ctrl_reset)
        else $error("controllers running during program mode");
    // buffer and fifo strobes
    AST_STALL: assert property (o_fifo_wvalid && !i_fifo_wready |=>
        o_fifo_wvalid && $stable(o_fifo_wdata))
        else $error("buffer head changed during stall");
    AST_POP: assert property (o_fifo_rpop |=> !o_fifo_rpop)
        else $error("fifo pop longer than one cycle");
endmodule // hpfd_host_port_asserts

bind hpfd_host_port hpfd_host_port_asserts u_chk (.i_clk, .i_srst, .i_rst_n,
    .i_data, .i_re_n, .i_program_mode, .i_target_sel, .i_cycle_done,
    .i_fifo_wready, .o_data, .o_data_oe, .o_word_stored, .o_pm_wr_usb,
    .o_pm_wr_sic, .o_pm_addr, .o_pm_instr, .o_ctrl_reset, .o_fifo_wvalid,
    .o_fifo_wdata, .o_fifo_rpop);

// File: tb/hpfd_proc_model.sv
// behavioural external processor on the host port pins
`timescale 1ns/10ps
module hpfd_proc_model (
    input wire logic i_clk,
    input wire logic i_word_stored,
    input wire logic [31:0] i_rdata,
    output logic [7:0] o_addr = 8'h00,
    output logic [31:0] o_data = 32'h0,
    output logic o_cs_n = 1'b1,
    output logic o_we_n = 1'b1,
    output logic o_re_n = 1'b1,
    output logic o_dma_ack_n = 1'b1,
    output logic o_sel = 1'b0,
    output logic o_program_mode = 1'b0,
    output logic o_done = 1'b0
);
    // one bus or dma access, strobes held past the sync lag
    task automatic acc(input logic [7:0] a, input logic [31:0] d,
            input logic wr, input logic dma, output logic [31:0] q);
        @(posedge i_clk);
        o_addr <= a;
        o_data <= d;
        o_cs_n <= dma;
        o_dma_ack_n <= !dma;
        o_we_n <= !wr;
        o_re_n <= wr;
        repeat (5) @(posedge i_clk);
        q = i_rdata;
        o_cs_n <= 1'b1;
        o_dma_ack_n <= 1'b1;
        o_we_n <= 1'b1;
        o_re_n <= 1'b1;
        o_data <= ~d; // released bus shows no stale word
        repeat (4) @(posedge i_clk);
    endtask

    // one firmware word cycle with stored/done handshake
    task automatic fw(input logic s, input logic [31:0] w);
        @(posedge i_clk);
        o_sel <= s;
        o_data <= w;
        o_cs_n <= 1'b0;
        o_we_n <= 1'b0;
        repeat (20) if (!i_word_stored) @(posedge i_clk);
        o_done <= 1'b1;
        repeat (20) if (i_word_stored) @(posedge i_clk);
        o_done <= 1'b0;
        o_cs_n <= 1'b1;
        o_we_n <= 1'b1;
        o_data <= ~w;
        repeat (4) @(posedge i_clk);
    endtask
endmodule // hpfd_proc_model

// File: tb/hpfd_host_port_tb.sv
// self-checking bench for the host port
`timescale 1ns/10ps
module hpfd_host_port_tb
    import hpfd_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_rst_n = 1'b1;
    logic i_clk_sel = 1'b0;
    logic i_ctl_we = 1'b0;
    logic [7:0] i_ctl_addr = 8'h00;
    logic [31:0] i_ctl_wdata = 32'h0;
    logic i_fifo_wready = 1'b0;
    logic i_fifo_rvalid = 1'b0;
    logic [31:0] i_fifo_rdata = 32'h0;
    logic [7:0] i_addr;
    logic [31:0] i_data, o_data, o_fifo_wdata, q, data;
    logic i_cs_n, i_we_n, i_re_n, i_dma_ack_n, i_target_sel;
    logic i_program_mode, i_cycle_done, o_data_oe, o_dma_req, o_word_stored;
    logic o_pm_wr_usb, o_pm_wr_sic, o_ctrl_reset, o_ext_clk_sel;
    logic o_fifo_wvalid, o_fifo_rpop;
    logic [15:0] o_pm_addr, o_pm_instr;
    logic [31:0] exp_reg [NUM_REGS];
    logic [31:0] win [3];
    logic [32:0] pm_last = 33'h0;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 15172;

    hpfd_host_port DUT (.i_clk, .i_srst, .i_rst_n, .i_clk_sel, .i_addr,
        .i_data, .o_data, .o_data_oe, .i_cs_n, .i_we_n, .i_re_n, .o_dma_req,
        .i_dma_ack_n, .i_target_sel, .i_program_mode, .i_cycle_done,
        .o_word_stored, .o_pm_wr_usb, .o_pm_wr_sic, .o_pm_addr, .o_pm_instr,
        .o_ctrl_reset, .o_ext_clk_sel, .i_ctl_we, .i_ctl_addr, .i_ctl_wdata,
        .o_fifo_wvalid, .o_fifo_wdata, .i_fifo_wready, .i_fifo_rvalid,
        .i_fifo_rdata, .o_fifo_rpop);
    hpfd_proc_model cpu (.i_clk, .i_word_stored(o_word_stored),
        .i_rdata(o_data), .o_addr(i_addr), .o_data(i_data), .o_cs_n(i_cs_n),
        .o_we_n(i_we_n), .o_re_n(i_re_n), .o_dma_ack_n(i_dma_ack_n),
        .o_sel(i_target_sel), .o_program_mode(i_program_mode), .o_done(i_cycle_done));

    // clock
    initial forever #12.5 i_clk = ~i_clk;

    // cycle limit and record of program memory writes
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (o_pm_wr_usb || o_pm_wr_sic)
            pm_last <= {o_pm_wr_sic, o_pm_instr, o_pm_addr};
        if (cycles == 5000) begin
            err_total = err_total + 1;
            results();
        end
    end

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic results();
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // what the host reads back after writing v
    function automatic logic [31:0] host_view(int i, logic [31:0] v);
        return HOST_WR_MASK[i] ? v : REG_RESET;
    endfunction

    // main sequence
    initial begin
        repeat (8) @(posedge i_clk);
        i_srst <= 1'b0;
        for (int i = 0; i < NUM_REGS; i++) begin
            cpu.acc(8'(4 * i), 32'h0, 1'b0, 1'b0, q);
            chk(q, REG_RESET);
            exp_reg[i] = $random(seed);
            cpu.acc(8'(4 * i), exp_reg[i], 1'b1, 1'b0, q);
        end
        cpu.acc(8'h8c, 32'hffff_ffff, 1'b1, 1'b0, q);
        cpu.acc(8'h01, 32'hffff_ffff, 1'b1, 1'b0, q);
        for (int i = 0; i < NUM_REGS; i++) begin
            cpu.acc(8'(4 * i), 32'h0, 1'b0, 1'b0, q);
            chk(q, host_view(i, exp_reg[i]));
        end
        cpu.acc(8'h8c, 32'h0, 1'b0, 1'b0, q);
        chk(q, 32'h0);
        cpu.acc(8'h01, 32'h0, 1'b0, 1'b0, q);
        chk(q, 32'h0);
        // usb side register written from inside
        @(posedge i_clk);
        i_ctl_we <= 1'b1;
        i_ctl_addr <= OFF_DEVICE_REQUEST;
        i_ctl_wdata <= exp_reg[1];
        @(posedge i_clk);
        i_ctl_we <= 1'b0;
        cpu.acc(OFF_DEVICE_REQUEST, 32'h0, 1'b0, 1'b0, q);
        chk(q, exp_reg[1]);
        // dma on, then fill the buffer while the fifo stalls
        cpu.acc(OFF_TRANSFER_MODE_SELECT, 32'h1, 1'b1, 1'b0, q);
        chk(32'(o_dma_req), 32'h1);
        for (int k = 0; k < 3; k++) begin
            win[k] = $random(seed);
            cpu.acc(OFF_FIFO_DATA_WINDOW, win[k], 1'b1, k[0], q);
        end
        chk(32'(o_dma_req), 32'h0);
        for (int k = 0; k < 2; k++) begin
            chk(32'(o_fifo_wvalid), 32'h1);
            chk(o_fifo_wdata, win[k]);
            @(posedge i_clk);
            i_fifo_wready <= 1'b1;
            @(posedge i_clk);
            i_fifo_wready <= 1'b0;
            @(posedge i_clk);
        end
        chk(32'(o_fifo_wvalid), 32'h0);
        i_fifo_rvalid <= 1'b1;
        i_fifo_rdata <= win[2];
        cpu.acc(OFF_FIFO_DATA_WINDOW, 32'h0, 1'b0, 1'b0, q);
        chk(q, win[2]);
        cpu.acc(OFF_FIFO_DATA_WINDOW, 32'h0, 1'b0, 1'b1, q);
        chk(q, win[2]);
        // done strobe outside program mode is ignored
        cpu.o_done <= 1'b1;
        repeat (5) @(posedge i_clk);
        chk(32'(o_word_stored), 32'h0);
        cpu.o_done <= 1'b0;
        // download both controllers, interface side first
        cpu.o_addr <= OFF_HOST_COMMAND;
        cpu.o_program_mode <= 1'b1;
        repeat (4) @(posedge i_clk);
        chk(32'(o_ctrl_reset), 32'h1);
        chk(32'(o_dma_req), 32'h0);
        for (int k = 0; k < 4; k++) begin
            data = $random(seed);
            cpu.fw(k < 2, data);
            chk(pm_last[31:0], data);
            chk(32'(pm_last[32]), 32'(k < 2));
        end
        cpu.o_program_mode <= 1'b0;
        repeat (8) @(posedge i_clk);
        chk(32'(o_ctrl_reset), 32'h0);
        chk(32'(o_fifo_wvalid), 32'h0);
        cpu.acc(OFF_HOST_COMMAND, 32'h0, 1'b0, 1'b0, q);
        chk(q, exp_reg[0]);
        // external clock strap
        i_clk_sel <= 1'b1;
        repeat (4) @(posedge i_clk);
        chk(32'(o_ext_clk_sel), 32'h1);
        // reset pin restores registers
        i_rst_n <= 1'b0;
        repeat (5) @(posedge i_clk);
        chk(32'(o_ctrl_reset), 32'h1);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        cpu.acc(OFF_HOST_COMMAND, 32'h0, 1'b0, 1'b0, q);
        chk(q, REG_RESET);
        results();
    end
endmodule // hpfd_host_port_tb
